/* hw/sfq_ctrl.sv */
// sfq_ctrl: host controller for a quad serial nor flash, commanded over avalon-mm.
// assumes the flash samples on rising and drives on falling serial clock edges,
// with output valid within 10 ns; pin levels are resolved by the surroundings.
//
// What this block does
// - quad read: opcode on one line, then 24-bit address, mode byte, four dummy clocks on four lines
// - quad reads only issued after software reports the quad enable flag set
// - mode byte A0 lets the next same read skip its opcode
// - continuous-read reset command clears continuous mode before other commands
// - quad word read forces address bit zero low, uses two dummy clocks
// - page program refused unless write enable was sent beforehand
// - single page program: opcode, three address bytes, data bytes on one line
// - chip select rises only right after the last bit of a whole byte
// - quad page program sends address and data on four lines, needs quad flag
// - sector erase: opcode and three address bytes, write enable required
// - erase frame ends right after the eighth bit of the last address byte
// - write enable is a lone opcode frame and arms program and erase
// - status read of the low byte allowed while idle, refused while continuous read mode is on
`timescale 1ns/1ps
module sfq_ctrl (
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic             chip_sel_n_o,
    output logic             sclk_o,
    input  wire logic [3:0]  data_line_i,
    output logic      [3:0]  data_line_o,
    output logic      [3:0]  data_line_oe_o
);

    sfq_pkg::sfq_regs_t q;
    sfq_pkg::sfq_regs_t n;

    logic       tick;
    logic       stall;
    logic [3:0] wsel;
    logic       w_bad;
    logic       rd_wait;
    logic [7:0] rx_next;

    function automatic logic [7:0] op_of(input logic [3:0] s);
        case (s)
            sfq_pkg::SEL_WRITE_ENABLE:   op_of = sfq_pkg::WRITE_ENABLE_OP;
            sfq_pkg::SEL_STATUS_READ:    op_of = sfq_pkg::STATUS_READ_OP;
            sfq_pkg::SEL_QUAD_READ:      op_of = sfq_pkg::QUAD_READ_OP;
            sfq_pkg::SEL_QUAD_WORD_READ: op_of = sfq_pkg::QUAD_WORD_READ_OP;
            sfq_pkg::SEL_PAGE_PROGRAM:   op_of = sfq_pkg::PAGE_PROGRAM_OP;
            sfq_pkg::SEL_QUAD_PROGRAM:   op_of = sfq_pkg::QUAD_PROGRAM_OP;
            sfq_pkg::SEL_SECTOR_ERASE:   op_of = sfq_pkg::SECTOR_ERASE_OP;
            sfq_pkg::SEL_BLOCK_ERASE:    op_of = sfq_pkg::BLOCK_ERASE_OP;
            default:                     op_of = sfq_pkg::CRM_RESET_OP;
        endcase
    endfunction: op_of

    function automatic logic is_read(input logic [3:0] s);
        is_read = (s == sfq_pkg::SEL_QUAD_READ) || (s == sfq_pkg::SEL_QUAD_WORD_READ);
    endfunction: is_read

    function automatic logic is_quad(input logic [3:0] s);
        is_quad = is_read(s) || (s == sfq_pkg::SEL_QUAD_PROGRAM);
    endfunction: is_quad

    function automatic logic has_wdata(input logic [3:0] s);
        has_wdata = (s == sfq_pkg::SEL_PAGE_PROGRAM) || (s == sfq_pkg::SEL_QUAD_PROGRAM);
    endfunction: has_wdata

    function automatic logic needs_wel(input logic [3:0] s);
        needs_wel = has_wdata(s) || (s == sfq_pkg::SEL_SECTOR_ERASE)
                    || (s == sfq_pkg::SEL_BLOCK_ERASE);
    endfunction: needs_wel

    // address word, with bit zero forced low for the word read
    function automatic logic [31:0] addr_word(input logic [3:0] s, input logic [23:0] a);
        addr_word = {a[23:1], (s == sfq_pkg::SEL_QUAD_WORD_READ) ? 1'b0 : a[0], 8'h00};
    endfunction: addr_word

    assign tick = (q.div == sfq_pkg::SCK_HALF_CYC - 3'h1);
    assign wsel = avs_writedata_i[3:0];
    assign w_bad = (wsel > sfq_pkg::SEL_CRM_RESET)
                   || (is_quad(wsel) && !avs_writedata_i[sfq_pkg::CMD_QUAD_BIT])
                   || (needs_wel(wsel) && !q.write_latch_flag)
                   || (q.cont && wsel != sfq_pkg::SEL_CRM_RESET && wsel != q.cont_kind);
    assign rd_wait = !q.rd_valid && (q.st != sfq_pkg::ST_IDLE)
                     && (is_read(q.sel) || q.sel == sfq_pkg::SEL_STATUS_READ);
    // hold the clock when the host side has not kept up
    assign stall = (q.st == sfq_pkg::ST_RDATA && !q.sclk && q.cnt == 5'h01 && q.rd_valid)
                   || (q.sclk && q.cnt == 5'h01 && !q.wr_valid
                       && ((q.st == sfq_pkg::ST_ADDR && has_wdata(q.sel))
                           || (q.st == sfq_pkg::ST_WDATA && q.bytes > 9'h001)));
    assign rx_next = q.wide ? {q.rx[3:0], q.sync2} : {q.rx[6:0], q.sync2[1]};

    always_comb begin
        n = q;
        n.sync1 = data_line_i;
        n.sync2 = q.sync1;
        n.div = tick ? 3'h0 : q.div + 3'h1;
        n.wait_r = 1'b1;
        // avalon slave: one cycle of waitrequest low per answered request
        if ((avs_read_i || avs_write_i) && q.wait_r) begin
            case (avs_address_i)
                sfq_pkg::REG_CMD: begin
                    if (avs_read_i) begin
                        n.wait_r = 1'b0;
                        n.rdata = {23'h0, q.quad_ok, 3'h0, q.keep, q.sel};
                    end else if (q.st == sfq_pkg::ST_IDLE) begin
                        n.wait_r = 1'b0;
                        n.quad_ok = avs_writedata_i[sfq_pkg::CMD_QUAD_BIT];
                        n.err = w_bad;
                        if (!w_bad) begin
                            n.sel = wsel;
                            n.keep = avs_writedata_i[sfq_pkg::CMD_KEEP_BIT];
                            n.cs_n = 1'b0;
                            n.sclk = 1'b0;
                            n.div = 3'h0;
                            n.bytes = (wsel == sfq_pkg::SEL_STATUS_READ) ? 9'h001 : q.len;
                            n.wr_valid = has_wdata(wsel) ? q.wr_valid : 1'b0;
                            n.rd_valid = 1'b0;
                            if (wsel == sfq_pkg::SEL_WRITE_ENABLE) begin
                                n.write_latch_flag = 1'b1;
                            end
                            if (needs_wel(wsel)) begin
                                n.write_latch_flag = 1'b0;
                            end
                            if (wsel == sfq_pkg::SEL_CRM_RESET) begin
                                n.cont = 1'b0;
                            end
                            if (is_read(wsel)) begin
                                n.cont = avs_writedata_i[sfq_pkg::CMD_KEEP_BIT];
                                n.cont_kind = wsel;
                            end
                            if (q.cont && wsel == q.cont_kind) begin
                                n.st = sfq_pkg::ST_ADDR;
                                n.sh = addr_word(wsel, q.addr);
                                n.cnt = sfq_pkg::ADDR_CLK_4;
                                n.wide = 1'b1;
                            end else begin
                                n.st = sfq_pkg::ST_OP;
                                n.sh = (wsel == sfq_pkg::SEL_CRM_RESET) ? 32'hFFFFFFFF
                                                                        : {op_of(wsel), 24'h0};
                                n.cnt = sfq_pkg::OP_CLK;
                                n.wide = (wsel == sfq_pkg::SEL_CRM_RESET);
                            end
                        end
                    end
                end
                sfq_pkg::REG_ADDR: begin
                    n.wait_r = 1'b0;
                    n.rdata = {8'h0, q.addr};
                    if (avs_write_i) begin
                        n.addr = avs_writedata_i[23:0];
                    end
                end
                sfq_pkg::REG_LEN: begin
                    n.wait_r = 1'b0;
                    n.rdata = {23'h0, q.len};
                    if (avs_write_i) begin
                        n.len = (avs_writedata_i[8:0] == 9'h000) ? 9'h001 : avs_writedata_i[8:0];
                    end
                end
                sfq_pkg::REG_DATA: begin
                    if (avs_write_i && !q.wr_valid) begin
                        n.wait_r = 1'b0;
                        n.wr_byte = avs_writedata_i[7:0];
                        n.wr_valid = 1'b1;
                    end else if (avs_read_i && !rd_wait) begin
                        n.wait_r = 1'b0;
                        n.rdata = {24'h0, q.rd_byte};
                        n.rd_valid = 1'b0;
                    end
                end
                sfq_pkg::REG_STAT: begin
                    n.wait_r = 1'b0;
                    n.rdata = {15'h0, q.stat_byte[0], q.stat_byte, 2'h0, q.wr_valid, q.rd_valid,
                               q.err, q.cont, q.write_latch_flag, q.st != sfq_pkg::ST_IDLE};
                end
                default: begin
                    n.wait_r = 1'b0;
                    n.rdata = 32'h0;
                end
            endcase
        end
        // serial engine: rising edge samples, falling edge shifts
        if (q.st != sfq_pkg::ST_IDLE && tick && !stall) begin
            if (q.st == sfq_pkg::ST_END) begin
                if (!q.cs_n) begin
                    n.cs_n = 1'b1;
                end else begin
                    n.st = sfq_pkg::ST_IDLE;
                end
            end else if (!q.sclk) begin
                n.sclk = 1'b1;
                if (q.st == sfq_pkg::ST_RDATA) begin
                    n.rx = rx_next;
                    if (q.cnt == 5'h01) begin
                        n.rd_byte = rx_next;
                        n.rd_valid = 1'b1;
                        if (q.sel == sfq_pkg::SEL_STATUS_READ) begin
                            n.stat_byte = rx_next;
                        end
                    end
                end
            end else begin
                n.sclk = 1'b0;
                if (q.cnt > 5'h01) begin
                    n.cnt = q.cnt - 5'h01;
                    n.sh = q.wide ? {q.sh[27:0], 4'h0} : {q.sh[30:0], 1'b0};
                end else begin
                    case (q.st)
                        sfq_pkg::ST_OP: begin
                            if (q.sel == sfq_pkg::SEL_STATUS_READ) begin
                                n.st = sfq_pkg::ST_RDATA;
                                n.cnt = sfq_pkg::BYTE_CLK_1;
                                n.wide = 1'b0;
                            end else if (q.sel == sfq_pkg::SEL_WRITE_ENABLE
                                         || q.sel == sfq_pkg::SEL_CRM_RESET) begin
                                n.st = sfq_pkg::ST_END;
                            end else begin
                                n.st = sfq_pkg::ST_ADDR;
                                n.sh = addr_word(q.sel, q.addr);
                                n.wide = is_quad(q.sel);
                                n.cnt = is_quad(q.sel) ? sfq_pkg::ADDR_CLK_4
                                                       : sfq_pkg::ADDR_CLK_1;
                            end
                        end
                        sfq_pkg::ST_ADDR: begin
                            if (is_read(q.sel)) begin
                                n.st = sfq_pkg::ST_MODE;
                                n.sh = {q.keep ? sfq_pkg::MODE_KEEP : sfq_pkg::MODE_EXIT, 24'h0};
                                n.cnt = sfq_pkg::MODE_CLK;
                            end else if (has_wdata(q.sel)) begin
                                n.st = sfq_pkg::ST_WDATA;
                                n.sh = {q.wr_byte, 24'h0};
                                n.wr_valid = 1'b0;
                                n.cnt = q.wide ? sfq_pkg::BYTE_CLK_4 : sfq_pkg::BYTE_CLK_1;
                            end else begin
                                n.st = sfq_pkg::ST_END;
                            end
                        end
                        sfq_pkg::ST_MODE: begin
                            n.st = sfq_pkg::ST_DUMMY;
                            n.cnt = (q.sel == sfq_pkg::SEL_QUAD_WORD_READ)
                                    ? sfq_pkg::DUMMY_CLK_WORD : sfq_pkg::DUMMY_CLK_READ;
                        end
                        sfq_pkg::ST_DUMMY: begin
                            n.st = sfq_pkg::ST_RDATA;
                            n.cnt = sfq_pkg::BYTE_CLK_4;
                        end
                        sfq_pkg::ST_WDATA: begin
                            n.bytes = q.bytes - 9'h001;
                            if (q.bytes == 9'h001) begin
                                n.st = sfq_pkg::ST_END;
                            end else begin
                                n.sh = {q.wr_byte, 24'h0};
                                n.wr_valid = 1'b0;
                                n.cnt = q.wide ? sfq_pkg::BYTE_CLK_4 : sfq_pkg::BYTE_CLK_1;
                            end
                        end
                        sfq_pkg::ST_RDATA: begin
                            n.bytes = q.bytes - 9'h001;
                            n.cnt = q.wide ? sfq_pkg::BYTE_CLK_4 : sfq_pkg::BYTE_CLK_1;
                            if (q.bytes == 9'h001) begin
                                n.st = sfq_pkg::ST_END;
                            end
                        end
                        default: begin
                            n.st = sfq_pkg::ST_IDLE;
                        end
                    endcase
                end
            end
        end
        // pin drive follows the next state and shift word
        case (n.st)
            sfq_pkg::ST_OP, sfq_pkg::ST_ADDR, sfq_pkg::ST_MODE, sfq_pkg::ST_WDATA: begin
                n.oe = n.wide ? 4'hF : 4'hD;
                n.dout = n.wide ? n.sh[31:28] : {3'b110, n.sh[31]};
            end
            sfq_pkg::ST_DUMMY, sfq_pkg::ST_RDATA: begin
                n.oe = n.wide ? 4'h0 : 4'hC;
                n.dout = 4'hC;
            end
            default: begin
                n.oe = 4'hC;
                n.dout = 4'hC;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            q <= sfq_pkg::REGS_RST;
        end else begin
            q <= n;
        end
    end

    assign avs_readdata_o    = q.rdata;
    assign avs_waitrequest_o = q.wait_r;
    assign chip_sel_n_o      = q.cs_n;
    assign sclk_o            = q.sclk;
    assign data_line_o       = q.dout;
    assign data_line_oe_o    = q.oe;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    cs_on_boundary_a: assert property ($rose(chip_sel_n_o) |->
        $past(q.st) == sfq_pkg::ST_END)
        else $error("chip select rose outside frame end");
    dummy_length_a: assert property ($rose(q.st == sfq_pkg::ST_DUMMY) |->
        q.cnt == ((q.sel == sfq_pkg::SEL_QUAD_WORD_READ) ? 5'h02 : 5'h04))
        else $error("wrong dummy clock count");
    word_a0_low_a: assert property ($rose(q.st == sfq_pkg::ST_ADDR)
        && q.sel == sfq_pkg::SEL_QUAD_WORD_READ |-> q.sh[8] == 1'b0)
        else $error("word read address bit zero not low");
    mode_byte_a: assert property ($rose(q.st == sfq_pkg::ST_MODE) |->
        q.sh[31:24] == (q.keep ? 8'hA0 : 8'h00) && data_line_oe_o == 4'hF)
        else $error("wrong mode byte");
    skip_opcode_a: assert property ($fell(chip_sel_n_o) && $past(q.cont)
        && $past(q.cont_kind) == q.sel |-> q.st == sfq_pkg::ST_ADDR && q.wide)
        else $error("continuous read did not skip opcode");
    quad_gate_a: assert property (q.st != sfq_pkg::ST_IDLE && q.wide
        && q.sel != sfq_pkg::SEL_CRM_RESET |-> q.quad_ok)
        else $error("quad transfer without quad flag");
    wel_needed_a: assert property ($fell(chip_sel_n_o) && needs_wel(q.sel) |->
        $past(q.write_latch_flag) && !q.write_latch_flag)
        else $error("program or erase without write enable");
    read_release_a: assert property (q.st == sfq_pkg::ST_RDATA && q.wide
        |-> data_line_oe_o == 4'h0)
        else $error("host drives lines during quad read");
    msb_first_a: assert property (!q.cs_n && !q.wide && data_line_oe_o == 4'hD
        |-> data_line_o[0] == q.sh[31])
        else $error("serial bit not msb first");
    clock_in_frame_a: assert property ($rose(sclk_o) |-> !chip_sel_n_o ##1 !chip_sel_n_o)
        else $error("serial clock outside chip select");

    quad_read_c: cover property ($rose(q.st == sfq_pkg::ST_RDATA) && q.wide && q.keep);
    cont_skip_c: cover property ($fell(chip_sel_n_o) && q.st == sfq_pkg::ST_ADDR);
    program_c: cover property ($rose(q.st == sfq_pkg::ST_END) && has_wdata(q.sel));
    erase_c: cover property ($rose(q.st == sfq_pkg::ST_END) && q.sel == sfq_pkg::SEL_SECTOR_ERASE);

endmodule: sfq_ctrl

/* hw/sfq_pkg.sv */
// sfq_pkg: constants, register map, state type and state record of the quad flash host.
// assumes a 200 MHz system clock and a flash that shifts out on falling serial clock edges.
package sfq_pkg;

    // flash opcodes
    localparam logic [7:0] WRITE_ENABLE_OP   = 8'h06;
    localparam logic [7:0] STATUS_READ_OP    = 8'h05;
    localparam logic [7:0] QUAD_READ_OP      = 8'hEB;
    localparam logic [7:0] QUAD_WORD_READ_OP = 8'hE7;
    localparam logic [7:0] PAGE_PROGRAM_OP   = 8'h02;
    localparam logic [7:0] QUAD_PROGRAM_OP   = 8'h32;
    localparam logic [7:0] SECTOR_ERASE_OP   = 8'h20;
    localparam logic [7:0] BLOCK_ERASE_OP    = 8'h52;
    localparam logic [7:0] CRM_RESET_OP      = 8'hFF;

    // command selects written to the command register
    localparam logic [3:0] SEL_WRITE_ENABLE   = 4'h0;
    localparam logic [3:0] SEL_STATUS_READ    = 4'h1;
    localparam logic [3:0] SEL_QUAD_READ      = 4'h2;
    localparam logic [3:0] SEL_QUAD_WORD_READ = 4'h3;
    localparam logic [3:0] SEL_PAGE_PROGRAM   = 4'h4;
    localparam logic [3:0] SEL_QUAD_PROGRAM   = 4'h5;
    localparam logic [3:0] SEL_SECTOR_ERASE   = 4'h6;
    localparam logic [3:0] SEL_BLOCK_ERASE    = 4'h7;
    localparam logic [3:0] SEL_CRM_RESET      = 4'h8;

    // register byte offsets
    localparam logic [4:0] REG_CMD  = 5'h00;
    localparam logic [4:0] REG_ADDR = 5'h04;
    localparam logic [4:0] REG_LEN  = 5'h08;
    localparam logic [4:0] REG_DATA = 5'h0C;
    localparam logic [4:0] REG_STAT = 5'h10;
    localparam int CMD_KEEP_BIT = 4;
    localparam int CMD_QUAD_BIT = 8;
    localparam logic [8:0] LEN_RST = 9'h001;

    // mode byte values and phase lengths in serial clocks
    localparam logic [7:0] MODE_KEEP      = 8'hA0;
    localparam logic [7:0] MODE_EXIT      = 8'h00;
    localparam logic [4:0] OP_CLK         = 5'h08;
    localparam logic [4:0] ADDR_CLK_1     = 5'h18;
    localparam logic [4:0] ADDR_CLK_4     = 5'h06;
    localparam logic [4:0] MODE_CLK       = 5'h02;
    localparam logic [4:0] DUMMY_CLK_READ = 5'h04;
    localparam logic [4:0] DUMMY_CLK_WORD = 5'h02;
    localparam logic [4:0] BYTE_CLK_1     = 5'h08;
    localparam logic [4:0] BYTE_CLK_4     = 5'h02;

    // serial clock timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int SCK_HALF_NS   = 20;
    localparam logic [2:0] SCK_HALF_CYC = 3'(SCK_HALF_NS / CLK_PERIOD_NS);

    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_OP    = 8'h02,
        ST_ADDR  = 8'h04,
        ST_MODE  = 8'h08,
        ST_DUMMY = 8'h10,
        ST_WDATA = 8'h20,
        ST_RDATA = 8'h40,
        ST_END   = 8'h80
    } sfq_state_t;

    typedef struct packed {
        sfq_state_t  st;
        logic [31:0] sh;
        logic [4:0]  cnt;
        logic        wide;
        logic [8:0]  bytes;
        logic [2:0]  div;
        logic        sclk;
        logic        cs_n;
        logic [3:0]  dout;
        logic [3:0]  oe;
        logic [7:0]  rx;
        logic [7:0]  rd_byte;
        logic        rd_valid;
        logic [7:0]  wr_byte;
        logic        wr_valid;
        logic [3:0]  sel;
        logic        keep;
        logic        quad_ok;
        logic [23:0] addr;
        logic [8:0]  len;
        logic        cont;
        logic [3:0]  cont_kind;
        logic        write_latch_flag;
        logic        err;
        logic [7:0]  stat_byte;
        logic [3:0]  sync1;
        logic [3:0]  sync2;
        logic        wait_r;
        logic [31:0] rdata;
    } sfq_regs_t;

    localparam sfq_regs_t REGS_RST = '{st: ST_IDLE, cs_n: 1'b1, wait_r: 1'b1, len: LEN_RST,
                                       dout: 4'hC, oe: 4'hC, default: '0};

endpackage: sfq_pkg

/* verif/sfq_flash_model.sv */
// sfq_flash_model: behavioural quad flash for the host bench.
// assumes the host shifts on falling and samples on rising serial clock edges.
`timescale 1ns/1ps
module sfq_flash_model (
    input  wire logic       cs_n_i,
    input  wire logic       sclk_i,
    input  wire logic [3:0] line_i,
    output logic      [3:0] line_o,
    output logic      [7:0] op_o,
    output logic            wel_o
);
    int         clks = 0;
    logic [7:0] op   = 8'h00;
    logic [7:0] sh   = 8'h00;
    logic       busy = 1'b0;
    // opcode implied by the next frame while continuous read mode is on
    logic [7:0] cop  = 8'h00;
    initial line_o = 4'h0;
    initial wel_o = 1'b0;
    always @(posedge sclk_i) if (!cs_n_i) begin
        if (clks < 8) op <= {op[6:0], line_i[0]};
        if (clks == 7) sh <= {6'h00, wel_o, busy};
        if (clks == 14 && (op == 8'hEB || op == 8'hE7)) cop <= (line_i == 4'hA) ? op : 8'h00;
        clks <= clks + 1;
    end
    // undriven lines flip every clock so stale values never pass
    always @(negedge sclk_i) begin
        if (op == 8'h05 && clks >= 8) line_o <= {2'h3, sh[7], 1'b1};
        else if (op == 8'hEB && clks >= 20 || op == 8'hE7 && clks >= 18) line_o <= 4'h5;
        else line_o <= ~line_o;
        sh <= {sh[6:0], 1'b0};
    end
    always @(posedge cs_n_i) begin
        if (op == 8'h06 && clks == 8) wel_o <= 1'b1;
        if (wel_o && (clks == 32 && (op == 8'h20 || op == 8'h52)
            || op == 8'h02 && clks >= 40 && clks % 8 == 0
            || op == 8'h32 && clks >= 16 && clks % 2 == 0)) begin
            busy <= 1'b1;
            wel_o <= 1'b0;
            busy <= #3000 1'b0;
        end
        op_o <= op;
        // continuous mode: next frame starts at the address, opcode implied
        clks <= (cop != 8'h00) ? 8 : 0;
        if (cop != 8'h00) op <= cop;
    end
endmodule: sfq_flash_model

/* verif/tb_serial_flash_quad_read_program_erase.sv */
// tb: register-level tests of the quad flash host over avalon-mm.
// assumes the flash model returns 8'h55 for every quad read byte.
`timescale 1ns/1ps
module tb_serial_flash_quad_read_program_erase;
    logic        mclk_i    = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [4:0]  adr       = 5'h00;
    logic        rd        = 1'b0;
    logic        wr        = 1'b0;
    logic [31:0] wd        = 32'h0;
    logic [31:0] rdat, q;
    logic        wt, cs_n, sclk, fwel;
    logic [3:0]  dout, oe, fout, line;
    logic [7:0]  fop;
    int          err_count   = 0;
    int          checks_done = 0;
    logic [31:0] sel [4] = '{32'h6, 32'h7, 32'h4, 32'h105};
    logic [7:0]  opc [4] = '{8'h20, 8'h52, 8'h02, 8'h32};
    assign line = (oe & dout) | (~oe & fout);
    sfq_ctrl DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wt),
        .chip_sel_n_o(cs_n), .sclk_o(sclk), .data_line_i(line), .data_line_o(dout),
        .data_line_oe_o(oe));
    sfq_flash_model FL (.cs_n_i(cs_n), .sclk_i(sclk), .line_i(line), .line_o(fout), .op_o(fop),
        .wel_o(fwel));
    initial forever #2.5 mclk_i = ~mclk_i;
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask: chk
    task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge mclk_i); while (wt !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask: xfer
    task automatic idle();
        xfer(1'b0, sfq_pkg::REG_STAT, 32'h0);
        for (int n = 0; n < 400 && q[0] !== 1'b0; n++) xfer(1'b0, sfq_pkg::REG_STAT, 32'h0);
    endtask: idle
    task automatic cmd(input logic [31:0] c);
        xfer(1'b1, sfq_pkg::REG_CMD, c);
        idle();
    endtask: cmd
    task automatic qread(input logic [31:0] c);
        xfer(1'b1, sfq_pkg::REG_LEN, 32'h2);
        xfer(1'b1, sfq_pkg::REG_CMD, c);
        repeat (2) begin
            xfer(1'b0, sfq_pkg::REG_DATA, 32'h0);
            chk("read byte", q[7:0], 8'h55);
        end
        idle();
    endtask: qread
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask: summarize
    initial begin
        #400000;
        err_count++;
        summarize();
    end
    initial begin
        repeat (5) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        xfer(1'b0, sfq_pkg::REG_LEN, 32'h0);
        chk("len reset", q, 32'h1);
        xfer(1'b0, 5'h14, 32'h0);
        chk("unmapped", q, 32'h0);
        cmd(32'h4);
        chk("program unarmed", q[3:0], 4'h8);
        cmd(32'h2);
        chk("quad unflagged", q[3:0], 4'h8);
        xfer(1'b1, sfq_pkg::REG_ADDR, 32'h100);
        for (int i = 0; i < 4; i++) begin
            cmd(32'h0);
            chk("write_enable_op", {q[3:1], fwel}, 4'h3);
            xfer(1'b1, sfq_pkg::REG_LEN, 32'h2);
            if (i > 1) xfer(1'b1, sfq_pkg::REG_DATA, 32'hA1);
            xfer(1'b1, sfq_pkg::REG_CMD, sel[i]);
            if (i > 1) xfer(1'b1, sfq_pkg::REG_DATA, 32'hB2);
            idle();
            chk("opcode", {q[1], fop}, {1'b0, opc[i]});
            cmd(32'h1);
            chk("flash busy", q[16], 1'b1);
            for (int n = 0; n < 40 && q[16] !== 1'b0; n++) cmd(32'h1);
            chk("flash done", {q[9], q[16]}, 2'h0);
        end
        qread(32'h112);
        chk("cont on", q[2], 1'b1);
        qread(32'h112);
        chk("read skip", {q[2], fop}, {1'b1, 8'hEB});
        cmd(32'h6);
        chk("cont refuse", q[3:2], 2'h3);
        cmd(32'h8);
        chk("cont reset", q[3:2], 2'h0);
        qread(32'h113);
        chk("word cont", q[2], 1'b1);
        qread(32'h113);
        chk("word skip", {q[2], fop}, {1'b1, 8'hE7});
        cmd(32'h8);
        qread(32'h103);
        chk("word plain", q[3:2], 2'h0);
        summarize();
    end
endmodule: tb_serial_flash_quad_read_program_erase
